// File: design/key_repeat.sv
// press and auto-repeat stepper for one navigation key
`timescale 1ns/1ps
`default_nettype none
module key_repeat (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic held,
  output var logic step
);
  import keymenu_pkg::*;

  logic held_r, held_nxt;
  logic rep_r, rep_nxt;
  logic [RW-1:0] cnt_r, cnt_nxt;
  logic step_nxt;

  always_comb begin
    held_nxt = held;
    rep_nxt = rep_r;
    cnt_nxt = cnt_r;
    step_nxt = 1'b0;
    if (!held) begin
      rep_nxt = 1'b0;
      cnt_nxt = RCNT_ZERO;
    end else if (!held_r) begin
      step_nxt = 1'b1;
      cnt_nxt = RCNT_ZERO;
    end else if (tick) begin
      // first repeat after the hold time, then at the fast rate
      if ((!rep_r && cnt_r == HOLD_LAST) ||
          (rep_r && cnt_r == REPEAT_LAST)) begin
        step_nxt = 1'b1;
        rep_nxt = 1'b1;
        cnt_nxt = RCNT_ZERO;
      end else begin
        cnt_nxt = cnt_r + 11'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_r <= 1'b0;
      rep_r <= 1'b0;
      cnt_r <= RCNT_ZERO;
      step <= 1'b0;
    end else begin
      held_r <= held_nxt;
      rep_r <= rep_nxt;
      cnt_r <= cnt_nxt;
      step <= step_nxt;
    end
  end

  a_step_released: assert property (@(posedge clk)
    disable iff (!rst_n) !held |=> !step)
    else $error("navigation step without key held");
  a_repeat_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (held && held_r && rep_r && tick && cnt_r == REPEAT_LAST) |=> step)
    else $error("fast repeat step missing");
  c_repeat: cover property (@(posedge clk) disable iff (!rst_n)
    step && rep_r);
endmodule : key_repeat
`default_nettype wire

// File: design/keymenu_pkg.sv
// shared constants and types for the keypad menu navigator
// How it works
// - setpoint key steps to the start of the next of six setpoint pages
// - measured key steps measured pages; from setpoints jumps to the first
// - section down/up move one section; stop at page end and page heading
// - section and line keys held over one second repeat at a fast rate
// - line right/left move one line; stop at last line and section heading
// - value up/down step the edited setpoint, clamped to its limits
// - value keys do nothing while a measured page is shown
// - an edited value stays local until committed; stored value stays active
// - commit writes the value to storage and flashes a stored message
// - commit acts only as store in setpoints or default select in measured
// - navigation never holds off the protection and control core
// - stop key drops both contactor relays
// - reset key clears a trip unless its cause remains; then flash refusal
// - assigned lockout trips clear only by the lockout switch
// - start A comes from the key, the rear switch or the serial port
// - start B comes from the key, the rear switch or the serial port
// - two minutes without a key shows the default message sequence
package keymenu_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_MS = 1000;
  localparam int REPEAT_MS = 100;
  localparam int FLASH_MS = 2000;
  localparam int IDLE_S = 120;
  localparam int IDLE_MS = IDLE_S * 1000;
  localparam int TW = 17;
  localparam int RW = 11;
  localparam int VW = 16;
  localparam logic [RW-1:0] HOLD_LAST = RW'(HOLD_MS - 1);
  localparam logic [RW-1:0] REPEAT_LAST = RW'(REPEAT_MS - 1);
  localparam logic [RW-1:0] FLASH_LAST = RW'(FLASH_MS - 1);
  localparam logic [RW-1:0] RCNT_ZERO = 11'h000;
  localparam logic [TW-1:0] TICK_LAST_D = TW'(TICK_CYCLES - 1);
  localparam logic [TW-1:0] IDLE_LAST_D = TW'(IDLE_MS - 1);
  localparam logic [TW-1:0] TCNT_ZERO = 17'h00000;
  localparam logic [2:0] PAGE_FIRST = 3'h0;
  localparam logic [2:0] SP_PAGE_LAST = 3'h5;
  localparam logic [2:0] ACT_PAGE_LAST = 3'h3;
  localparam logic [3:0] POS_HEAD = 4'h0;
  localparam logic [VW-1:0] VAL_ZERO = 16'h0000;
  localparam logic [VW-1:0] VAL_STEP = 16'h0001;
  localparam int NAV_KEYS = 4;
  localparam int NAV_UP = 0;
  localparam int NAV_DOWN = 1;
  localparam int NAV_LEFT = 2;
  localparam int NAV_RIGHT = 3;

  typedef enum logic [2:0] {
    ST_SP = 3'b001,
    ST_ACT = 3'b010,
    ST_DFLT = 3'b100
  } mode_t;

  typedef struct packed {
    logic setpoint;
    logic actual;
    logic store;
    logic stop;
    logic reset;
    logic start_a;
    logic start_b;
    logic up;
    logic down;
    logic left;
    logic right;
    logic val_up;
    logic val_down;
  } keys_t;

  typedef struct packed {
    keys_t keys;
    logic lockout_sw;
    logic start_a_sw;
    logic start_b_sw;
  } pins_t;

  typedef struct packed {
    logic trip_active;
    logic cause_present;
    logic lockout_trip;
    logic lockout_assign;
    logic motor_running;
  } core_t;

  typedef struct packed {
    logic [3:0] sect_last;
    logic [3:0] line_last;
  } geom_t;

  typedef struct packed {
    logic [2:0] page;
    logic [3:0] sect;
    logic [3:0] line;
  } pos_t;

  typedef struct packed {
    mode_t mode;
    pos_t pos;
    logic flash_stored;
    logic flash_no_reset;
    logic status_msg;
  } disp_t;

  typedef struct packed {
    logic stop;
    logic trip_clear;
    logic start_a;
    logic start_b;
    logic dflt_sel;
    logic nv_we;
  } cmd_t;
endpackage : keymenu_pkg

// File: design/keypad_menu_navigator.sv
// keypad menu navigator: paging, editing, commit and motor commands
`timescale 1ns/1ps
`default_nettype none
module keypad_menu_navigator #(
  parameter logic [keymenu_pkg::TW-1:0] TICK_LAST = keymenu_pkg::TICK_LAST_D,
  parameter logic [keymenu_pkg::TW-1:0] IDLE_LAST = keymenu_pkg::IDLE_LAST_D
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire keymenu_pkg::pins_t pins,
  input wire logic serial_start_a,
  input wire logic serial_start_b,
  input wire keymenu_pkg::core_t core,
  input wire keymenu_pkg::geom_t geom,
  input wire logic [keymenu_pkg::VW-1:0] sp_stored,
  input wire logic [keymenu_pkg::VW-1:0] sp_min,
  input wire logic [keymenu_pkg::VW-1:0] sp_max,
  output var keymenu_pkg::disp_t disp,
  output var logic [keymenu_pkg::VW-1:0] edit_value,
  output var keymenu_pkg::pos_t nv_addr,
  output var logic [keymenu_pkg::VW-1:0] nv_data,
  output var keymenu_pkg::cmd_t cmd
);
  import keymenu_pkg::*;

  // pin synchroniser and edge detection
  pins_t s1_r, s2_r, prev_r;
  pins_t rise;
  assign rise = s2_r & ~prev_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      prev_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      prev_r <= s2_r;
    end
  end

  // millisecond tick
  logic [TW-1:0] tcnt_r, tcnt_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    tick_nxt = (tcnt_r == TICK_LAST);
    tcnt_nxt = tick_nxt ? TCNT_ZERO : tcnt_r + 17'h00001;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tcnt_r <= TCNT_ZERO;
      tick_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // navigation keys with auto-repeat
  logic [NAV_KEYS-1:0] nav_held;
  logic [NAV_KEYS-1:0] nav_step;
  assign nav_held[NAV_UP] = s2_r.keys.up;
  assign nav_held[NAV_DOWN] = s2_r.keys.down;
  assign nav_held[NAV_LEFT] = s2_r.keys.left;
  assign nav_held[NAV_RIGHT] = s2_r.keys.right;

  for (genvar i = 0; i < NAV_KEYS; i++) begin : g_nav
    key_repeat u_rep (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick_r),
      .held(nav_held[i]),
      .step(nav_step[i])
    );
  end

  logic any_press;
  assign any_press = (|rise.keys) || (|nav_step);

  // menu position, edit value and display state
  mode_t mode_r, mode_nxt;
  pos_t pos_r, pos_nxt;
  logic [VW-1:0] edit_r, edit_nxt;
  logic load_r, load_nxt;
  logic [TW-1:0] idle_r, idle_nxt;
  logic [RW-1:0] fcnt_r, fcnt_nxt;
  logic fstored_r, fstored_nxt;
  logic fnores_r, fnores_nxt;
  logic on_setpoint;
  logic moved;

  assign on_setpoint = (mode_r == ST_SP) && (pos_r.line != POS_HEAD);

  always_comb begin
    mode_nxt = mode_r;
    pos_nxt = pos_r;
    edit_nxt = edit_r;
    moved = 1'b0;
    if (rise.keys.setpoint) begin
      moved = 1'b1;
      pos_nxt.sect = POS_HEAD;
      pos_nxt.line = POS_HEAD;
      if (mode_r != ST_SP) begin
        mode_nxt = ST_SP;
        pos_nxt.page = PAGE_FIRST;
      end else if (pos_r.page == SP_PAGE_LAST) begin
        pos_nxt.page = PAGE_FIRST;
      end else begin
        pos_nxt.page = pos_r.page + 3'h1;
      end
    end else if (rise.keys.actual) begin
      moved = 1'b1;
      pos_nxt.sect = POS_HEAD;
      pos_nxt.line = POS_HEAD;
      if (mode_r != ST_ACT) begin
        mode_nxt = ST_ACT;
        pos_nxt.page = PAGE_FIRST;
      end else if (pos_r.page == ACT_PAGE_LAST) begin
        pos_nxt.page = PAGE_FIRST;
      end else begin
        pos_nxt.page = pos_r.page + 3'h1;
      end
    end else if (nav_step[NAV_DOWN]) begin
      if (pos_r.sect != geom.sect_last) begin
        moved = 1'b1;
        pos_nxt.sect = pos_r.sect + 4'h1;
        pos_nxt.line = POS_HEAD;
      end
    end else if (nav_step[NAV_UP]) begin
      if (pos_r.sect != POS_HEAD) begin
        moved = 1'b1;
        pos_nxt.sect = pos_r.sect - 4'h1;
        pos_nxt.line = POS_HEAD;
      end
    end else if (nav_step[NAV_RIGHT]) begin
      if (pos_r.line != geom.line_last) begin
        moved = 1'b1;
        pos_nxt.line = pos_r.line + 4'h1;
      end
    end else if (nav_step[NAV_LEFT]) begin
      if (pos_r.line != POS_HEAD) begin
        moved = 1'b1;
        pos_nxt.line = pos_r.line - 4'h1;
      end
    end else if (rise.keys.val_up && on_setpoint && !load_r) begin
      edit_nxt = (edit_r >= sp_max) ? sp_max : edit_r + VAL_STEP;
    end else if (rise.keys.val_down && on_setpoint && !load_r) begin
      edit_nxt = (edit_r <= sp_min) ? sp_min : edit_r - VAL_STEP;
    end
    // any other key leaves the default sequence for measured values
    if (mode_r == ST_DFLT && any_press && mode_nxt == ST_DFLT) begin
      mode_nxt = ST_ACT;
    end
    if (load_r) begin
      edit_nxt = sp_stored;
    end
    load_nxt = moved;
    // idle timer, key presses restart it
    idle_nxt = idle_r;
    if (any_press) begin
      idle_nxt = TCNT_ZERO;
    end else if (tick_r && mode_r != ST_DFLT) begin
      if (idle_r == IDLE_LAST) begin
        mode_nxt = ST_DFLT;
        idle_nxt = TCNT_ZERO;
      end else begin
        idle_nxt = idle_r + 17'h00001;
      end
    end
  end

  // commit, reset and motor commands
  cmd_t cmd_nxt;
  logic lock_ok;
  logic panel_ok;

  assign lock_ok = core.trip_active && !core.cause_present;
  assign panel_ok = !(core.lockout_trip && core.lockout_assign);

  always_comb begin
    cmd_nxt = '0;
    fstored_nxt = fstored_r;
    fnores_nxt = fnores_r;
    fcnt_nxt = fcnt_r;
    if (tick_r && (fstored_r || fnores_r)) begin
      if (fcnt_r == FLASH_LAST) begin
        fstored_nxt = 1'b0;
        fnores_nxt = 1'b0;
        fcnt_nxt = RCNT_ZERO;
      end else begin
        fcnt_nxt = fcnt_r + 11'h001;
      end
    end
    if (rise.keys.store) begin
      if (on_setpoint && !load_r) begin
        cmd_nxt.nv_we = 1'b1;
        fstored_nxt = 1'b1;
        fcnt_nxt = RCNT_ZERO;
      end else if (mode_r == ST_ACT) begin
        cmd_nxt.dflt_sel = 1'b1;
      end
    end
    cmd_nxt.stop = rise.keys.stop;
    if (rise.keys.reset && core.trip_active) begin
      if (core.cause_present || !panel_ok) begin
        fnores_nxt = 1'b1;
        fcnt_nxt = RCNT_ZERO;
      end else begin
        cmd_nxt.trip_clear = 1'b1;
      end
    end
    if (rise.lockout_sw && lock_ok) begin
      cmd_nxt.trip_clear = 1'b1;
    end
    cmd_nxt.start_a = rise.keys.start_a || rise.start_a_sw ||
                      serial_start_a;
    cmd_nxt.start_b = rise.keys.start_b || rise.start_b_sw ||
                      serial_start_b;
  end

  // outputs are registered; the core sees commands independent of the menu
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= ST_DFLT;
      pos_r <= '0;
      edit_r <= VAL_ZERO;
      load_r <= 1'b0;
      idle_r <= TCNT_ZERO;
      fcnt_r <= RCNT_ZERO;
      fstored_r <= 1'b0;
      fnores_r <= 1'b0;
      cmd <= '0;
      nv_addr <= '0;
      nv_data <= VAL_ZERO;
    end else begin
      mode_r <= mode_nxt;
      pos_r <= pos_nxt;
      edit_r <= edit_nxt;
      load_r <= load_nxt;
      idle_r <= idle_nxt;
      fcnt_r <= fcnt_nxt;
      fstored_r <= fstored_nxt;
      fnores_r <= fnores_nxt;
      cmd <= cmd_nxt;
      if (cmd_nxt.nv_we) begin
        nv_addr <= pos_r;
        nv_data <= edit_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      disp <= '{ST_DFLT, '0, 1'b0, 1'b0, 1'b0};
      edit_value <= VAL_ZERO;
    end else begin
      disp.mode <= mode_nxt;
      disp.pos <= pos_nxt;
      disp.flash_stored <= fstored_nxt;
      disp.flash_no_reset <= fnores_nxt;
      disp.status_msg <= !core.motor_running;
      edit_value <= edit_nxt;
    end
  end

  // checks
  a_sp_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.setpoint && mode_r == ST_SP && pos_r.page == SP_PAGE_LAST)
    |=> pos_r.page == PAGE_FIRST && mode_r == ST_SP)
    else $error("setpoint page did not wrap");
  a_sp_next: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.setpoint && mode_r == ST_SP && pos_r.page != SP_PAGE_LAST)
    |=> pos_r.page == $past(pos_r.page) + 3'h1 && pos_r.sect == POS_HEAD)
    else $error("setpoint page did not advance");
  a_act_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.actual && !rise.keys.setpoint && mode_r == ST_SP)
    |=> mode_r == ST_ACT && pos_r.page == PAGE_FIRST)
    else $error("measured key did not jump to first page");
  a_sect_end: assert property (@(posedge clk) disable iff (!rst_n)
    (nav_step[NAV_DOWN] && !rise.keys.setpoint && !rise.keys.actual &&
     pos_r.sect == geom.sect_last) |=> $stable(pos_r))
    else $error("section down moved past page end");
  a_line_head: assert property (@(posedge clk) disable iff (!rst_n)
    (nav_step[NAV_LEFT] && $onehot(nav_step) && !rise.keys.setpoint &&
     !rise.keys.actual && pos_r.line == POS_HEAD) |=> $stable(pos_r))
    else $error("line left moved at section heading");
  a_val_clamp: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == ST_SP && !load_r && !moved && edit_r >= sp_max &&
     rise.keys.val_up) |=> edit_r == $past(sp_max))
    else $error("value up passed maximum");
  a_val_floor: assert property (@(posedge clk) disable iff (!rst_n)
    (on_setpoint && !load_r && !moved && nav_step == '0 &&
     !rise.keys.val_up && rise.keys.val_down && edit_r <= sp_min)
    |=> edit_r == $past(sp_min))
    else $error("value down passed minimum");
  a_val_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == ST_ACT && !load_r) |=> $stable(edit_r))
    else $error("value changed on measured page");
  a_no_commit: assert property (@(posedge clk) disable iff (!rst_n)
    !(rise.keys.store && on_setpoint) |=> !cmd.nv_we)
    else $error("storage written without commit");
  a_store_flash: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.store && on_setpoint && !load_r) |=>
    cmd.nv_we && nv_data == $past(edit_r) ##1 disp.flash_stored)
    else $error("commit did not write and flash");
  a_store_act: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.store && mode_r == ST_ACT) |=> cmd.dflt_sel && !cmd.nv_we)
    else $error("commit on measured page misbehaved");
  a_stop_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    rise.keys.stop |=> cmd.stop)
    else $error("stop key gave no stop command");
  a_reset_block: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.reset && core.trip_active && core.cause_present)
    |=> !cmd.trip_clear ##1 disp.flash_no_reset)
    else $error("trip cleared while cause present");
  a_lockout: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.reset && !rise.lockout_sw && core.lockout_trip &&
     core.lockout_assign) |=> !cmd.trip_clear)
    else $error("panel reset cleared a lockout trip");
  a_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.start_a || rise.start_a_sw || serial_start_a)
    |=> cmd.start_a)
    else $error("start A request lost");
  a_start_b: assert property (@(posedge clk) disable iff (!rst_n)
    (rise.keys.start_b || rise.start_b_sw || serial_start_b)
    |=> cmd.start_b)
    else $error("start B request lost");
  a_idle_dflt: assert property (@(posedge clk) disable iff (!rst_n)
    (tick_r && !any_press && idle_r == IDLE_LAST) |=> mode_r == ST_DFLT)
    else $error("idle timeout missed");

  c_wrap: cover property (@(posedge clk) disable iff (!rst_n)
    rise.keys.setpoint && mode_r == ST_SP && pos_r.page == SP_PAGE_LAST);
  c_store: cover property (@(posedge clk) disable iff (!rst_n) cmd.nv_we);
  c_idle: cover property (@(posedge clk) disable iff (!rst_n)
    mode_r == ST_ACT ##1 mode_r == ST_DFLT);
  c_refuse: cover property (@(posedge clk) disable iff (!rst_n)
    disp.flash_no_reset);
endmodule : keypad_menu_navigator
`default_nettype wire

// File: tb/keypad_menu_navigator_tb.sv
// self-checking bench for the keypad menu navigator
`timescale 1ns/1ps
`default_nettype none
module keypad_menu_navigator_tb;
  import keymenu_pkg::*;
  localparam int TICKC = 10;
  localparam int IDLE_T = 2000;
  localparam int K_SP = 15, K_ACT = 14, K_STORE = 13, K_STOP = 12, K_RST = 11;
  localparam int K_SA = 10, K_SB = 9, K_UP = 8, K_DN = 7, K_LF = 6, K_RT = 5;
  localparam int K_VU = 4, K_VD = 3, K_LOCK = 2, K_SWA = 1, K_SWB = 0;
  logic clk;
  logic rst_n;
  logic serial_start_a;
  logic serial_start_b;
  pins_t pins;
  core_t core;
  geom_t geom;
  logic [VW-1:0] sp_stored, sp_min, sp_max, edit_value, nv_data, ev;
  disp_t disp;
  pos_t nv_addr;
  cmd_t cmd;
  int bad_count = 0, n_tests = 0, cyc = 0, n = 0;
  int n_stop = 0, n_clr = 0, n_sa = 0, n_sb = 0, n_dflt = 0, n_we = 0;

  keypad_menu_navigator #(.TICK_LAST(17'h00009), .IDLE_LAST(17'h007CF))
    u_keypad_menu_navigator (.clk(clk), .rst_n(rst_n), .pins(pins),
    .serial_start_a(serial_start_a), .serial_start_b(serial_start_b),
    .core(core), .geom(geom), .sp_stored(sp_stored), .sp_min(sp_min),
    .sp_max(sp_max), .disp(disp), .edit_value(edit_value),
    .nv_addr(nv_addr), .nv_data(nv_data), .cmd(cmd));
  menu_table_model u_menu_table_model (.clk(clk), .pos(disp.pos),
    .nv_we(cmd.nv_we), .nv_addr(nv_addr), .nv_data(nv_data), .geom(geom),
    .sp_stored(sp_stored), .sp_min(sp_min), .sp_max(sp_max));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // one-cycle command pulses are counted as they appear
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rst_n === 1'b1) begin
      n_stop <= n_stop + int'(cmd.stop === 1'b1);
      n_clr <= n_clr + int'(cmd.trip_clear === 1'b1);
      n_sa <= n_sa + int'(cmd.start_a === 1'b1);
      n_sb <= n_sb + int'(cmd.start_b === 1'b1);
      n_dflt <= n_dflt + int'(cmd.dflt_sel === 1'b1);
      n_we <= n_we + int'(cmd.nv_we === 1'b1);
    end
    if (cyc == 60000) begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic done(input string t);
    $display("test %s finished, mismatches so far %0d", t, bad_count);
  endtask : done

  // press one pin, hold it, release and let the outputs settle
  task automatic hit(input int idx, input int hold);
    @(posedge clk);
    pins <= pins_t'(16'h0001 << idx);
    repeat (hold) @(posedge clk);
    pins <= '0;
    repeat (6) @(posedge clk);
    #1;
  endtask : hit

  task automatic set_core(input core_t c);
    @(posedge clk);
    core <= c;
  endtask : set_core

  initial begin
    pins = '0;
    core = '0;
    serial_start_a = 1'b0;
    serial_start_b = 1'b0;
    rst_n = 1'b0;
    void'($urandom(32'hF132F141));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    hit(K_SP, 6);
    chk(disp.mode === ST_SP && disp.pos === '0, "sp");
    for (int k = 1; k <= 6; k++) begin
      hit(K_SP, 6);
      chk(disp.pos === pos_t'{3'(k % 6), 4'h0, 4'h0}, "page");
    end
    done("setpoint paging");
    hit(K_UP, 6);
    chk(disp.pos.sect === 4'h0, "up at page heading");
    for (int k = 1; k <= 16; k++) begin
      hit(K_DN, 6);
      chk(disp.pos.sect === 4'(k > 15 ? 15 : k), "section down");
    end
    hit(K_UP, 6);
    chk(disp.pos.sect === 4'hE, "section up");
    hit(K_LF, 6);
    chk(disp.pos.line === 4'h0, "left at section heading");
    for (int k = 1; k <= 4; k++) begin
      hit(K_RT, 6);
      chk(disp.pos.line === 4'(k > 3 ? 3 : k), "line right");
    end
    hit(K_LF, 6);
    chk(disp.pos.line === 4'h2, "line left");
    done("sections and lines");
    chk(edit_value === 16'h0006, "edit value load");
    n = $urandom % 5 + 3;
    ev = 16'(6 + n > 8 ? 8 : 6 + n);
    repeat (n) hit(K_VU, 6);
    chk(edit_value === ev, "value up clamp");
    chk(sp_stored === 16'h0006 && n_we == 0, "edit kept local");
    repeat (5) hit(K_VD, 6);
    chk(edit_value === 16'h0005, "value down clamp");
    hit(K_STORE, 6);
    chk(n_we == 1 && nv_data === 16'h0005, "commit write");
    chk(nv_addr === pos_t'{3'h0, 4'hE, 4'h2}, "commit place");
    chk(disp.flash_stored === 1'b1 && sp_stored === 16'h5, "flash");
    hit(K_STOP, 6);
    chk(n_stop == 1 && disp.mode === ST_SP, "stop in menu");
    done("editing");
    hit(K_SP, 6);
    @(posedge clk);
    pins <= pins_t'(16'h0001 << K_DN);
    repeat (900 * TICKC) @(posedge clk);
    #1;
    chk(disp.pos.sect === 4'h1, "one step before repeat");
    repeat (350 * TICKC) @(posedge clk);
    #1;
    chk(disp.pos.sect === 4'h4, "fast repeat");
    @(posedge clk);
    pins <= '0;
    repeat (300) @(posedge clk);
    #1;
    chk(disp.pos.sect === 4'h4, "repeat stops on release");
    done("auto repeat");
    hit(K_ACT, 6);
    chk(disp.mode === ST_ACT && disp.pos === '0, "act");
    for (int k = 1; k <= 4; k++) begin
      hit(K_ACT, 6);
      chk(disp.pos.page === 3'(k % 4), "measured page");
    end
    hit(K_RT, 6);
    ev = edit_value;
    hit(K_VU, 6);
    hit(K_VD, 6);
    chk(edit_value === ev, "value keys in measured");
    hit(K_STORE, 6);
    chk(n_dflt == 1 && n_we == 1, "store selects default");
    done("measured values");
    set_core(core_t'(5'h18));
    hit(K_RST, 6);
    chk(n_clr == 0 && disp.flash_no_reset === 1'b1, "refused");
    set_core(core_t'(5'h16));
    hit(K_RST, 6);
    chk(n_clr == 0, "lockout trip held at panel");
    hit(K_LOCK, 6);
    chk(n_clr == 1, "lockout switch clears");
    set_core(core_t'(5'h14));
    hit(K_RST, 6);
    chk(n_clr == 2, "panel reset clears");
    set_core(core_t'(5'h00));
    hit(K_RST, 6);
    chk(n_clr == 2, "reset without trip");
    done("trip reset");
    for (int k = 0; k < 2; k++) begin
      hit(k ? K_SB : K_SA, 6);
      hit(k ? K_SWB : K_SWA, 6);
      @(posedge clk);
      if (k == 1) serial_start_b <= 1'b1;
      else serial_start_a <= 1'b1;
      @(posedge clk);
      serial_start_a <= 1'b0;
      serial_start_b <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(n_sa == 3 && n_sb == 3 * k, "start sources");
    end
    done("start commands");
    set_core(core_t'({4'h0, 1'($urandom)}));
    repeat ((IDLE_T - 5) * TICKC) @(posedge clk);
    #1;
    chk(disp.mode === ST_ACT, "no early timeout");
    repeat (10 * TICKC) @(posedge clk);
    #1;
    chk(disp.mode === ST_DFLT, "idle timeout");
    chk(disp.flash_no_reset === 1'b0, "flash ends");
    chk(disp.status_msg === ~core.motor_running, "default message");
    hit(K_SP, 6);
    chk(disp.mode === ST_SP && disp.pos.page === 3'h0, "after idle");
    done("idle timeout");
    final_report();
  end
endmodule : keypad_menu_navigator_tb
`default_nettype wire

// File: tb/menu_table_model.sv
// far-side model: menu geometry, setpoint limits and setpoint storage
`timescale 1ns/1ps
`default_nettype none
module menu_table_model #(
  parameter logic [3:0] SECT_LAST = 4'hF,
  parameter logic [3:0] LINE_LAST = 4'h3,
  parameter logic [keymenu_pkg::VW-1:0] INIT_VAL = 16'h0006,
  parameter logic [keymenu_pkg::VW-1:0] MIN_VAL = 16'h0005,
  parameter logic [keymenu_pkg::VW-1:0] MAX_VAL = 16'h0008
) (
  input wire logic clk,
  input wire keymenu_pkg::pos_t pos,
  input wire logic nv_we,
  input wire keymenu_pkg::pos_t nv_addr,
  input wire logic [keymenu_pkg::VW-1:0] nv_data,
  output var keymenu_pkg::geom_t geom,
  output var logic [keymenu_pkg::VW-1:0] sp_stored,
  output var logic [keymenu_pkg::VW-1:0] sp_min,
  output var logic [keymenu_pkg::VW-1:0] sp_max
);
  import keymenu_pkg::*;
  logic [VW-1:0] mem [0:2047];
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = INIT_VAL;
    end
  end
  // only a commit reaches storage
  always @(posedge clk) begin
    if (nv_we === 1'b1) begin
      mem[nv_addr] <= nv_data;
    end
  end
  assign geom = '{sect_last: SECT_LAST, line_last: LINE_LAST};
  assign sp_stored = mem[pos];
  assign sp_min = MIN_VAL;
  assign sp_max = MAX_VAL;
endmodule : menu_table_model
`default_nettype wire
